// [core/adcp_ctrl.sv]
// Controller that drives a 1M x 1 asynchronous page-mode DRAM by its strobes
//
// Summary of operation
// RULE1: Pause strobes high, then eight refresh cycles
// RULE2: Reads keep write enable high past strobes
// RULE3: Write enable falls before column strobe: early write
// RULE4: Late write enable makes read-modify-write cycle
// RULE5: Otherwise delayed write; lead times must hold
// RULE6: Reads: strobes low, write enable high
// RULE7: Read data valid while column strobe low
// RULE8: Access bounded by row, column or address
// RULE9: Excess row-to-column delay adds to access
// RULE10: All 512 rows refreshed every 64 ms
// RULE11: Row-only refresh: column strobe high, output off
// RULE12: Column before row strobe uses internal address
// RULE13: Internal refresh counter advances each such refresh
// RULE14: Hidden refresh keeps previous read data
// RULE15: Page column cycles never count as refresh
// RULE16: Column strobe high for page precharge minimum
// RULE17: Page access counted from column strobe rise
// RULE18: Row and column halves share address pins
// RULE19: Write data taken at later strobe fall
// RULE20: Spread refreshes evenly, one per interval
`timescale 1ns/10ps
`default_nettype none

module adcp_ctrl #(
    parameter int   PAUSE_CYC   = adcp_pkg::PAUSE_CYC,
    parameter int   REF_CYC     = adcp_pkg::REF_CYC,
    parameter int   RAS_MAX_CYC = adcp_pkg::RAS_MAX_CYC,
    parameter logic USE_CBR     = 1'b1
) (
    input  wire logic                ref_clk_i,
    input  wire logic                arst_n_i,
    input  wire logic                ce_i,
    input  wire logic                req_i,
    input  wire adcp_pkg::adcp_req_t req_data_i,
    input  wire logic                dram_dout_i,
    output logic                     ack_o,
    output logic                     rdata_o,
    output logic                     init_done_o,
    output adcp_pkg::adcp_pins_t     dram_o
);

    localparam int TW = adcp_pkg::TW;
    localparam int AW = adcp_pkg::AW;

    localparam adcp_pkg::adcp_state_t ST_PAUSE   = adcp_pkg::ST_PAUSE;
    localparam adcp_pkg::adcp_state_t ST_REF_SET = adcp_pkg::ST_REF_SET;
    localparam adcp_pkg::adcp_state_t ST_REF_RAS = adcp_pkg::ST_REF_RAS;
    localparam adcp_pkg::adcp_state_t ST_REF_END = adcp_pkg::ST_REF_END;
    localparam adcp_pkg::adcp_state_t ST_IDLE    = adcp_pkg::ST_IDLE;
    localparam adcp_pkg::adcp_state_t ST_ROW_SET = adcp_pkg::ST_ROW_SET;
    localparam adcp_pkg::adcp_state_t ST_ROW     = adcp_pkg::ST_ROW;
    localparam adcp_pkg::adcp_state_t ST_COL_SET = adcp_pkg::ST_COL_SET;
    localparam adcp_pkg::adcp_state_t ST_COL     = adcp_pkg::ST_COL;
    localparam adcp_pkg::adcp_state_t ST_CAS_UP  = adcp_pkg::ST_CAS_UP;
    localparam adcp_pkg::adcp_state_t ST_PRE     = adcp_pkg::ST_PRE;

    function automatic logic [TW-1:0] ld(input int c);
        return TW'(c - 1);
    endfunction

    // ========================================================================
    // State
    // ========================================================================
    adcp_pkg::adcp_state_t           state_reg, state_next;
    adcp_pkg::adcp_pins_t            pins_reg, pins_next;
    adcp_pkg::adcp_req_t             op_reg, op_next;
    logic                            ack_reg, ack_next;
    logic                            rdata_reg, rdata_next;
    logic                            init_done_reg, init_done_next;
    logic [adcp_pkg::INIT_W-1:0]     init_cnt_reg, init_cnt_next;
    logic [adcp_pkg::ROW_W-1:0]      ref_row_reg, ref_row_next;
    logic [TW-1:0]                   ref_tick_reg;
    logic                            ref_pend_reg;
    logic                            ref_clr;
    logic [TW-1:0]                   ras_open_reg;
    logic                            tmr_load;
    logic [TW-1:0]                   tmr_val;
    logic                            tmr_done;
    logic                            pause_armed_reg;
    logic                            tmr_load_pause;

    // ========================================================================
    // Decoding
    // ========================================================================
    wire logic          ref_tick_end = (ref_tick_reg == TW'(REF_CYC - 1));
    wire logic          same_row     = (req_data_i.addr[2*AW-1:AW] == op_reg.addr[2*AW-1:AW]);
    wire logic          ras_too_long = (ras_open_reg >= TW'(RAS_MAX_CYC - adcp_pkg::PAGE_MARGIN));
    wire logic          page_ok      = req_i && same_row && !ref_pend_reg && !ras_too_long;
    wire logic [AW-1:0] ref_addr     = AW'(ref_row_reg);

    adcp_timer #(
        .W      (TW)
    ) u_phase_timer (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .ce_i      (ce_i),
        .load_i    (tmr_load),
        .val_i     (tmr_val),
        .done_o    (tmr_done)
    );

    // ========================================================================
    // Strobe sequencer
    // ========================================================================
    always_comb begin
        state_next     = state_reg;
        pins_next      = pins_reg;
        op_next        = op_reg;
        ack_next       = 1'b0;
        rdata_next     = rdata_reg;
        init_done_next = init_done_reg;
        init_cnt_next  = init_cnt_reg;
        ref_row_next   = ref_row_reg;
        ref_clr        = 1'b0;
        tmr_load       = 1'b0;
        tmr_val        = '0;
        case (state_reg)
            ST_PAUSE: begin
                // First cycle after reset arms the power-up pause
                if (tmr_load_pause) begin                           // [RULE1]
                    tmr_load = 1'b1;
                    tmr_val  = ld(PAUSE_CYC);
                end else if (tmr_done) begin                        // [RULE1]
                    state_next = ST_REF_SET;
                end
            end
            ST_REF_SET: begin
                // Column strobe leads the row strobe, or the row address is set up
                pins_next.cas_n = !USE_CBR;                         // [RULE12] [RULE11]
                pins_next.addr  = ref_addr;
                pins_next.we_n  = 1'b1;
                tmr_load        = 1'b1;
                tmr_val         = ld(adcp_pkg::CSR_CYC);
                state_next      = ST_REF_RAS;
            end
            ST_REF_RAS: begin
                if (tmr_done && pins_reg.ras_n) begin
                    pins_next.ras_n = 1'b0;
                    ref_clr         = 1'b1;
                    tmr_load        = 1'b1;
                    tmr_val         = ld(adcp_pkg::RAS_CYC);
                end else if (tmr_done) begin
                    pins_next.ras_n = 1'b1;
                    pins_next.cas_n = 1'b1;
                    tmr_load        = 1'b1;
                    tmr_val         = ld(adcp_pkg::RP_CYC);
                    state_next      = ST_REF_END;
                end
            end
            ST_REF_END: begin
                if (tmr_done) begin
                    ref_row_next = ref_row_reg + 1'b1;              // [RULE10]
                    if (!init_done_reg) begin
                        init_cnt_next = init_cnt_reg + 1'b1;
                        if (init_cnt_reg == adcp_pkg::INIT_W'(adcp_pkg::INIT_CYCLES - 1)) begin
                            init_done_next = 1'b1;                  // [RULE1]
                            state_next     = ST_IDLE;
                        end else begin
                            state_next = ST_REF_SET;
                        end
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_IDLE: begin
                if (ref_pend_reg) begin                             // [RULE20]
                    state_next = ST_REF_SET;
                end else if (req_i) begin
                    op_next        = req_data_i;
                    pins_next.addr = req_data_i.addr[2*AW-1:AW];    // [RULE18]
                    pins_next.we_n = 1'b1;
                    state_next     = ST_ROW_SET;
                end
            end
            ST_ROW_SET: begin
                pins_next.ras_n = 1'b0;                             // [RULE6]
                tmr_load        = 1'b1;
                tmr_val         = ld(adcp_pkg::RCD_CYC);
                state_next      = ST_ROW;
            end
            ST_ROW: begin
                if (tmr_done) begin
                    pins_next.addr = op_reg.addr[AW-1:0];           // [RULE18]
                    pins_next.we_n = !op_reg.write;                 // [RULE3] [RULE19]
                    pins_next.din  = op_reg.wdata;
                    state_next     = ST_COL_SET;
                end
            end
            ST_COL_SET: begin
                pins_next.cas_n = 1'b0;
                tmr_load        = 1'b1;
                // Covers row, column and page access paths alike
                tmr_val         = ld(adcp_pkg::ACC_CYC);            // [RULE8] [RULE9] [RULE17]
                state_next      = ST_COL;
            end
            ST_COL: begin
                if (tmr_done) begin
                    rdata_next      = dram_dout_i;                  // [RULE7]
                    ack_next        = 1'b1;
                    pins_next.cas_n = 1'b1;
                    tmr_load        = 1'b1;
                    tmr_val         = ld(adcp_pkg::CP_CYC);         // [RULE16]
                    state_next      = ST_CAS_UP;
                end
            end
            ST_CAS_UP: begin
                // Write enable stays as is until here, past the column strobe rise
                pins_next.we_n = 1'b1;                              // [RULE2] [RULE5]
                if (tmr_done && page_ok) begin                      // [RULE15]
                    op_next        = req_data_i;
                    pins_next.addr = req_data_i.addr[AW-1:0];
                    pins_next.we_n = !req_data_i.write;             // [RULE3]
                    pins_next.din  = req_data_i.wdata;
                    state_next     = ST_COL_SET;
                end else if (tmr_done) begin
                    pins_next.ras_n = 1'b1;
                    tmr_load        = 1'b1;
                    tmr_val         = ld(adcp_pkg::RP_CYC);
                    state_next      = ST_PRE;
                end
            end
            ST_PRE: begin
                if (tmr_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg     <= ST_PAUSE;
            pins_reg      <= adcp_pkg::PINS_RESET;
            op_reg        <= '0;
            ack_reg       <= 1'b0;
            rdata_reg     <= 1'b0;
            init_done_reg <= 1'b0;
            init_cnt_reg  <= '0;
            ref_row_reg   <= '0;
        end else if (ce_i) begin
            state_reg     <= state_next;
            pins_reg      <= pins_next;
            op_reg        <= op_next;
            ack_reg       <= ack_next;
            rdata_reg     <= rdata_next;
            init_done_reg <= init_done_next;
            init_cnt_reg  <= init_cnt_next;
            ref_row_reg   <= ref_row_next;
        end
    end

    // ========================================================================
    // Pause, refresh interval and row-open timing
    // ========================================================================
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pause_armed_reg <= 1'b0;
        end else if (ce_i) begin
            pause_armed_reg <= 1'b1;
        end
    end

    assign tmr_load_pause = !pause_armed_reg;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ref_tick_reg <= '0;
            ref_pend_reg <= 1'b0;
        end else if (ce_i) begin
            ref_tick_reg <= ref_tick_end ? '0 : ref_tick_reg + TW'(1);
            // A new tick wins over the clear of the same cycle
            ref_pend_reg <= (ref_tick_end && init_done_reg)
                            || (ref_pend_reg && !ref_clr);          // [RULE10] [RULE20]
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ras_open_reg <= '0;
        end else if (ce_i) begin
            ras_open_reg <= pins_reg.ras_n ? '0 : ras_open_reg + TW'(1);
        end
    end

    assign ack_o       = ack_reg;
    assign rdata_o     = rdata_reg;
    assign init_done_o = init_done_reg;
    assign dram_o      = pins_reg;

    // ========================================================================
    // Checks
    // ========================================================================
    init_strobes_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE1]
        !init_done_reg && state_reg == ST_PAUSE |-> pins_reg.ras_n && pins_reg.cas_n)
        else $error("strobes not high during power-up pause");

    read_we_high_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE2]
        $rose(pins_reg.cas_n) && !op_reg.write |-> pins_reg.we_n ##1 pins_reg.we_n)
        else $error("write enable low around end of read");

    early_write_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE3]
        $fell(pins_reg.cas_n) && !pins_reg.ras_n |-> pins_reg.we_n == !op_reg.write)
        else $error("write enable not set up before column strobe");

    cas_precharge_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE16]
        $rose(pins_reg.cas_n) |=> pins_reg.cas_n [*2])
        else $error("column strobe precharge too short");

    cbr_order_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE12]
        $fell(pins_reg.ras_n) && !pins_reg.cas_n |-> state_reg == ST_REF_RAS && USE_CBR)
        else $error("column strobe low at row fall outside refresh");

    read_data_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE7]
        ack_reg |-> rdata_reg == $past(dram_dout_i) && $past(!pins_reg.cas_n))
        else $error("read data not sampled while column strobe low");

    refresh_first_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE20]
        state_reg == ST_IDLE && ref_pend_reg && ce_i |=> state_reg == ST_REF_SET)
        else $error("pending refresh not served from idle");

    row_addr_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE18]
        $fell(pins_reg.ras_n) && pins_reg.cas_n && init_done_reg && state_reg == ST_ROW
        |-> pins_reg.addr == op_reg.addr[2*AW-1:AW])
        else $error("row address not on pins at row strobe fall");

    ras_width_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE8]
        $rose(pins_reg.ras_n) |-> $past(ras_open_reg) >= TW'(adcp_pkg::RAS_CYC - 1))
        else $error("row strobe low time too short");

endmodule

`default_nettype wire

// [common/adcp_pkg.sv]
// Shared constants and types for the asynchronous DRAM strobe controller
package adcp_pkg;

    // ========================================================================
    // Clock and timing figures (ns unless marked)
    // ========================================================================
    localparam int CLK_NS        = 4;
    localparam int T_PAUSE_NS    = 200000;
    localparam int T_REF_MS      = 64;
    localparam int REF_ROWS      = 512;
    localparam int INIT_CYCLES   = 8;
    localparam int T_RAS_NS      = 70;
    localparam int T_RAS_MAX_NS  = 100000;
    localparam int T_RP_NS       = 60;
    localparam int T_RCD_NS      = 20;
    localparam int T_CAS_NS      = 25;
    localparam int T_CAC_NS      = 25;
    localparam int T_RAC_NS      = 70;
    localparam int T_CP_NS       = 10;
    localparam int T_CPA_NS      = 53;
    localparam int T_CSR_NS      = 0;
    localparam int T_CWL_NS      = 17;
    localparam int T_RWL_NS      = 22;

    // ========================================================================
    // Cycle conversion
    // ========================================================================
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_dn(input int ns);
        int c;
        c = ns / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam int PAUSE_CYC   = cyc_up(T_PAUSE_NS);
    localparam int REF_CYC     = cyc_dn(T_REF_MS * 1000000 / REF_ROWS);
    localparam int RAS_MAX_CYC = cyc_dn(T_RAS_MAX_NS);
    localparam int RAS_CYC     = cyc_up(T_RAS_NS);
    localparam int RP_CYC      = cyc_up(T_RP_NS);
    localparam int RCD_CYC     = cyc_up(T_RCD_NS);
    localparam int CP_CYC      = cyc_up(T_CP_NS);
    localparam int CSR_CYC     = cyc_up(T_CSR_NS);
    // Column strobe low time; one extra cycle lets output data settle
    localparam int ACC_CYC     = 1 + imax(imax(cyc_up(T_CAS_NS), cyc_up(T_CAC_NS)),
                                      imax(imax(cyc_up(T_RAC_NS) - RCD_CYC,
                                                cyc_up(T_CPA_NS) - CP_CYC),
                                           imax(cyc_up(T_CWL_NS), cyc_up(T_RWL_NS))));
    // Page must close before the row strobe low limit
    localparam int PAGE_MARGIN = ACC_CYC + CP_CYC + 4;

    // ========================================================================
    // Widths and types
    // ========================================================================
    localparam int TW       = 16;
    localparam int AW       = 10;
    localparam int ROW_W    = 9;
    localparam int INIT_W   = 4;

    typedef struct packed {
        logic          ras_n;
        logic          cas_n;
        logic          we_n;
        logic [AW-1:0] addr;
        logic          din;
    } adcp_pins_t;

    typedef struct packed {
        logic            write;
        logic [2*AW-1:0] addr;
        logic            wdata;
    } adcp_req_t;

    typedef enum logic [3:0] {
        ST_PAUSE, ST_REF_SET, ST_REF_RAS, ST_REF_END, ST_IDLE,
        ST_ROW_SET, ST_ROW, ST_COL_SET, ST_COL, ST_CAS_UP, ST_PRE
    } adcp_state_t;

    localparam adcp_pins_t PINS_RESET = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                          addr: '0, din: 1'b0};

endpackage

// [core/adcp_timer.sv]
// Loadable down counter that times each strobe phase
`timescale 1ns/10ps
`default_nettype none

module adcp_timer #(
    parameter int W = 16
) (
    input  wire logic         ref_clk_i,
    input  wire logic         arst_n_i,
    input  wire logic         ce_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] val_i,
    output logic              done_o
);

    logic [W-1:0] cnt_reg;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= '0;
        end else if (ce_i) begin
            if (load_i) begin
                cnt_reg <= val_i;
            end else if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - W'(1);
            end
        end
    end

    assign done_o = (cnt_reg == '0);

endmodule

`default_nettype wire

// [core/adcp_dummy_unused.sv]
`timescale 1ns/10ps

// [dv/adcp_dram.sv]
// Behavioural model of the 1M x 1 page-mode DRAM seen on the strobe pins
`timescale 1ns/10ps
`default_nettype none

module adcp_dram #(
    parameter int CP_NS = 10,
    parameter int OH_NS = 7
) (
    input  wire logic       ras_n_i,
    input  wire logic       cas_n_i,
    input  wire logic       we_n_i,
    input  wire logic [9:0] addr_i,
    input  wire logic       din_i,
    input  wire logic       slow_i,
    output logic            dout_o
);
    bit         mem [int];
    logic [9:0] row_q    = '0;
    logic [8:0] cbr_row  = '0;
    logic       rd_cyc   = 1'b0;
    logic       last_q   = 1'b0;
    int         cbr_cnt  = 0;
    int         ras_cnt  = 0;
    int         viol     = 0;
    realtime    t_cas_up = 0;
    realtime    t_cbr    = 0;
    realtime    max_gap  = 0;
    realtime    t_first  = 0;

    initial dout_o = 1'b1;

    // ========================================================================
    // Row strobe: refresh or row latch
    // ========================================================================
    always @(negedge ras_n_i) begin
        if (t_first == 0)
            t_first = $realtime;
        if (!cas_n_i) begin
            if (cbr_cnt > 0 && $realtime - t_cbr > max_gap)
                max_gap = $realtime - t_cbr;
            t_cbr = $realtime;
            cbr_cnt++;
            cbr_row <= cbr_row + 9'h001;
        end else begin
            row_q = addr_i;
            ras_cnt++;
        end
        t_cas_up = 0;
    end

    // ========================================================================
    // Column strobe: access, output drive and release
    // ========================================================================
    always @(negedge cas_n_i) begin
        if (t_first == 0)
            t_first = $realtime;
        if (!ras_n_i) begin
            if (cbr_cnt < 8 || (t_cas_up > 0 && $realtime - t_cas_up < CP_NS))
                viol++;
            rd_cyc = we_n_i;
            if (!we_n_i)
                mem[int'({row_q, addr_i})] = din_i;
            else begin
                last_q = mem.exists(int'({row_q, addr_i})) ? mem[int'({row_q, addr_i})] : 1'b0;
                dout_o = ~last_q;
                dout_o <= #(slow_i ? 50 : 2) last_q;
            end
        end
    end

    always @(posedge cas_n_i) begin
        t_cas_up = $realtime;
        if (rd_cyc)
            dout_o <= #(OH_NS) ~last_q;
        rd_cyc = 1'b0;
    end

    // Late write enable inside a column cycle is never expected here
    always @(negedge we_n_i) begin
        if (!ras_n_i && !cas_n_i) begin
            viol++;
            mem[int'({row_q, addr_i})] = din_i;
        end
    end
endmodule

`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the DRAM strobe controller
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    localparam int PAUSE = 20;
    localparam int REFC  = 200;
    localparam int RASM  = 200;

    logic                 ref_clk_i   = 1'b0;
    logic                 arst_n_i    = 1'b0;
    logic                 ce_i        = 1'b1;
    logic                 req_i       = 1'b0;
    adcp_pkg::adcp_req_t  req_data_i  = '0;
    logic                 slow        = 1'b0;
    logic                 dout;
    logic                 ack_o;
    logic                 rdata_o;
    logic                 init_done_o;
    adcp_pkg::adcp_pins_t dram_o;
    int                   fail_count  = 0;
    int                   check_count = 0;
    logic [19:0]          addrs [6]   = '{20'h00000, 20'hFFFFF, 20'h2A155,
                                          20'h155AA, 20'h00401, 20'h3FC00};

    always #2 ref_clk_i = ~ref_clk_i;

    adcp_ctrl #(.PAUSE_CYC(PAUSE), .REF_CYC(REFC), .RAS_MAX_CYC(RASM)) adcp_ctrl_inst (
        .ref_clk_i   (ref_clk_i),
        .arst_n_i    (arst_n_i),
        .ce_i        (ce_i),
        .req_i       (req_i),
        .req_data_i  (req_data_i),
        .dram_dout_i (dout),
        .ack_o       (ack_o),
        .rdata_o     (rdata_o),
        .init_done_o (init_done_o),
        .dram_o      (dram_o)
    );

    adcp_dram adcp_dram_inst (
        .ras_n_i (dram_o.ras_n),
        .cas_n_i (dram_o.cas_n),
        .we_n_i  (dram_o.we_n),
        .addr_i  (dram_o.addr),
        .din_i   (dram_o.din),
        .slow_i  (slow),
        .dout_o  (dout)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic access(input logic wr, input logic [19:0] a, input logic d, output logic q);
        int n;
        n = 0;
        req_i      <= 1'b1;
        req_data_i <= '{write: wr, addr: a, wdata: d};
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 2000);
        chk(n < 2000, 1'b1);
        q = rdata_o;
    endtask

    task automatic drop_req();
        req_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic wait_init(input int c0);
        int n;
        n = 0;
        while (init_done_o !== 1'b1 && n < 5000) begin
            @(posedge ref_clk_i);
            n++;
        end
        chk(adcp_dram_inst.cbr_cnt - c0, adcp_pkg::INIT_CYCLES);
    endtask

    task automatic t_init();
        chk({dram_o.ras_n, dram_o.cas_n, init_done_o}, 3'h6);
        wait_init(0);
        chk(adcp_dram_inst.t_first >= PAUSE * 4 + 16, 1'b1);
    endtask

    task automatic t_rw(input logic s);
        logic q;
        slow <= s;
        foreach (addrs[i]) begin
            access(1'b1, addrs[i], ^addrs[i] ^ s, q);
            chk(adcp_dram_inst.row_q, addrs[i][19:10]);
        end
        foreach (addrs[i]) begin
            access(1'b0, addrs[i], 1'b0, q);
            chk(q, ^addrs[i] ^ s);
        end
        drop_req();
    endtask

    task automatic t_page();
        logic q;
        int   r0;
        int   c0;
        r0 = adcp_dram_inst.ras_cnt;
        c0 = adcp_dram_inst.cbr_cnt;
        for (int i = 0; i < 4; i++)
            access(1'b1, {10'h2C3, 10'(i * 9)}, i[0], q);
        for (int i = 0; i < 4; i++) begin
            access(1'b0, {10'h2C3, 10'(i * 9)}, 1'b0, q);
            chk(q, i[0]);
        end
        drop_req();
        chk(adcp_dram_inst.ras_cnt - r0, 1 + adcp_dram_inst.cbr_cnt - c0);
        chk(adcp_dram_inst.viol, 0);
    endtask

    task automatic t_refresh();
        int c0;
        c0 = adcp_dram_inst.cbr_cnt;
        repeat (REFC * 5) @(posedge ref_clk_i);
        chk(adcp_dram_inst.cbr_cnt - c0 >= 4, 1'b1);
        chk(adcp_dram_inst.cbr_row, 9'(adcp_dram_inst.cbr_cnt));
        chk(adcp_dram_inst.max_gap <= (REFC + RASM + 40) * 4, 1'b1);
    endtask

    task automatic t_ce();
        adcp_pkg::adcp_pins_t p;
        int                   c0;
        @(posedge ref_clk_i);
        ce_i <= 1'b0;
        @(posedge ref_clk_i);
        p  = dram_o;
        c0 = adcp_dram_inst.cbr_cnt;
        repeat (REFC + 10) begin
            @(posedge ref_clk_i);
            chk(dram_o, p);
        end
        chk(adcp_dram_inst.cbr_cnt, c0);
        ce_i <= 1'b1;
    endtask

    task automatic t_reset();
        logic q;
        int   c0;
        @(posedge ref_clk_i);
        arst_n_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        chk({dram_o.ras_n, dram_o.cas_n, dram_o.we_n, ack_o, init_done_o}, 5'h1C);
        c0 = adcp_dram_inst.cbr_cnt;
        arst_n_i <= 1'b1;
        wait_init(c0);
        access(1'b0, addrs[2], 1'b0, q);
        chk(q, ~^addrs[2]);
        drop_req();
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        t_init();
        t_rw(1'b0);
        t_rw(1'b1);
        t_page();
        t_refresh();
        t_ce();
        t_reset();
        chk(adcp_dram_inst.viol, 0);
        results();
    end

    initial begin
        #200000;
        fail_count++;
        results();
    end
endmodule

`default_nettype wire
